// file: pdw_cfg.svh
// constants for the power-down, wake-up and watchdog block
`ifndef PDW_CFG_SVH
`define PDW_CFG_SVH

`define PDW_ADR_WDOG_CTL 8'h00
`define PDW_ADR_SYSCTL 8'h04
`define PDW_ADR_CLKMODE 8'h08
`define PDW_ADR_WAKEMASK 8'h0c
`define PDW_ADR_STATUS 8'h10

`define PDW_WDOG_CTL_RESET 8'h53
`define PDW_KEY_OK_A 5'h15
`define PDW_KEY_OK_B 5'h0a
`define PDW_KEY_DEBOUNCE 2'h2

`define PDW_SYSCTL_KEEP_BIT 7
`define PDW_SYSCTL_FSEL_HI 5
`define PDW_SYSCTL_FSEL_LO 4
`define PDW_SYSCTL_LVR_BIT 2
`define PDW_SYSCTL_SPARE_BIT 1
`define PDW_SYSCTL_KEYRST_BIT 0
`define PDW_SYSCTL_RW_MASK 8'hb6

`define PDW_CLKMODE_IDLE_BIT 1
`define PDW_CLKMODE_RW_MASK 8'he3
`define PDW_CLKMODE_RESET 8'h03

`define PDW_STATUS_TMO_BIT 5
`define PDW_STATUS_PD_BIT 4

`define PDW_WDT_W 18

`endif

// file: pdw_pkg.sv
// types shared by the power-down, wake-up and watchdog block
package pdw_pkg;

  typedef enum logic [3:0] {
    PDW_RUN = 4'b0001,
    PDW_SLEEP = 4'b0010,
    PDW_IDLE_OFF = 4'b0100,
    PDW_IDLE_ON = 4'b1000
  } pdw_state_t;

  typedef struct packed {
    logic [4:0] guard_key;
    logic [2:0] period_sel;
  } pdw_wdog_ctl_t;

  typedef struct packed {
    logic sys_clk_en;
    logic time_base_en;
    logic cpu_hold;
  } pdw_pwr_t;

endpackage

// file: pdw_wdt.sv
// watchdog counter on the sub clock tick with selectable period
`timescale 1ns/1ps
`include "pdw_cfg.svh"

module pdw_wdt
  import pdw_pkg::*;
#(
  parameter int CNT_W = `PDW_WDT_W
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic clear_i,
  input wire logic [2:0] period_sel_i,
  output logic timeout_o
);

  logic [CNT_W-1:0] cnt;

  // mask of the low counter bits that make up the selected period
  function automatic logic [CNT_W-1:0] period_mask(input logic [2:0] sel);
    logic [4:0] bits;
    bits = 5'h0;
    case (sel)
      3'h0: bits = 5'h08;
      3'h1: bits = 5'h0a;
      3'h2: bits = 5'h0c;
      3'h3: bits = 5'h0e;
      3'h4: bits = 5'h0f;
      3'h5: bits = 5'h10;
      3'h6: bits = 5'h11;
      default: bits = 5'h12;
    endcase
    period_mask = CNT_W'((19'h1 << bits) - 19'h1);
  endfunction

  logic [CNT_W-1:0] mask;
  logic wrap;
  assign mask = period_mask(period_sel_i);
  assign wrap = tick_i && ((cnt & mask) == mask);

  always_ff @(posedge clk_i)
  begin
    if (rst_i || clear_i || wrap)
      cnt <= '0;
    else if (tick_i)
      cnt <= cnt + CNT_W'(1);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || clear_i)
      timeout_o <= 1'b0;
    else
      timeout_o <= wrap;
  end

endmodule // pdw_wdt

// file: pdw_wake.sv
// wake-up detector for port a falling edges and interrupt requests
`timescale 1ns/1ps

module pdw_wake
#(
  parameter int PORT_W = 8,
  parameter int IRQ_W = 4
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic arm_i,
  input wire logic active_i,
  input wire logic [PORT_W-1:0] port_i,
  input wire logic [PORT_W-1:0] port_mask_i,
  input wire logic [IRQ_W-1:0] irq_req_i,
  output logic port_wake_o,
  output logic [IRQ_W-1:0] irq_wake_o
);

  logic [PORT_W-1:0] port_prev;
  logic [IRQ_W-1:0] irq_blocked;
  logic [PORT_W-1:0] port_fall;
  logic [IRQ_W-1:0] irq_new;

  assign port_fall = port_prev & ~port_i & port_mask_i;
  assign irq_new = irq_req_i & ~irq_blocked;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      port_prev <= '0;
    else if (arm_i || tick_i)
      port_prev <= port_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_blocked <= '0;
    else if (arm_i)
      irq_blocked <= irq_req_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || arm_i || !active_i)
    begin
      port_wake_o <= 1'b0;
      irq_wake_o <= '0;
    end
    else if (tick_i)
    begin
      port_wake_o <= |port_fall;
      irq_wake_o <= irq_new;
    end
    else
    begin
      port_wake_o <= 1'b0;
      irq_wake_o <= '0;
    end
  end

endmodule // pdw_wake

// file: pdw_top.sv
// power-down control, wake-up and watchdog with wishbone registers
`timescale 1ns/1ps
`include "pdw_cfg.svh"

module pdw_top
  import pdw_pkg::*;
#(
  parameter int PORT_W = 8,
  parameter int IRQ_W = 4
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic halt_i,
  input wire logic clear_watchdog_instr_i,
  input wire logic sub_clk_i,
  input wire logic [PORT_W-1:0] porta_i,
  input wire logic [IRQ_W-1:0] irq_req_i,
  input wire logic [IRQ_W-1:0] irq_en_i,
  input wire logic stack_full_i,
  output pdw_pwr_t pwr_o,
  output pdw_state_t mode_o,
  output logic device_reset_o,
  output logic pc_sp_reset_o,
  output logic wake_o,
  output logic irq_service_o,
  output logic powerdown_flag_o,
  output logic timeout_flag_o
);

  pdw_state_t state;
  pdw_state_t next_state;
  pdw_wdog_ctl_t wdog_ctl;
  logic [7:0] sysctl;
  logic [7:0] clkmode;
  logic [PORT_W-1:0] wake_mask;
  logic pd_flag;
  logic tof;
  logic key_rst_flag;

  // pin synchronisers; the first stage feeds only the second
  logic sub_s1;
  logic sub_s2;
  logic sub_s3;
  logic [PORT_W-1:0] porta_s1;
  logic [PORT_W-1:0] porta_s2;
  logic sub_tick;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sub_s1 <= 1'b0;
      sub_s2 <= 1'b0;
      sub_s3 <= 1'b0;
      porta_s1 <= '1;
      porta_s2 <= '1;
    end
    else
    begin
      sub_s1 <= sub_clk_i;
      sub_s2 <= sub_s1;
      sub_s3 <= sub_s2;
      porta_s1 <= porta_i;
      porta_s2 <= porta_s1;
    end
  end

  assign sub_tick = sub_s2 && !sub_s3;

  // device reset: power-on, normal timeout or bad key
  logic soft_rst;
  logic any_rst;
  logic in_pd;
  logic wdt_to;
  logic key_bad;
  logic [1:0] key_cnt;
  logic key_fire;
  logic halt_take;
  logic wdt_clear;

  assign soft_rst = device_reset_o;
  assign any_rst = rst_i || soft_rst;
  assign in_pd = (state != PDW_RUN);
  assign halt_take = halt_i && (state == PDW_RUN);
  assign key_bad = (wdog_ctl.guard_key != `PDW_KEY_OK_A) &&
                   (wdog_ctl.guard_key != `PDW_KEY_OK_B);
  assign key_fire = key_bad && sub_tick && (key_cnt == `PDW_KEY_DEBOUNCE);

  assign wdt_clear = halt_take || clear_watchdog_instr_i || key_fire;

  // debounce a bad guard key on sub clock
  always_ff @(posedge clk_i)
  begin
    if (any_rst || !key_bad)
      key_cnt <= 2'h0;
    else if (sub_tick && key_cnt != `PDW_KEY_DEBOUNCE)
      key_cnt <= key_cnt + 2'h1;
  end

  pdw_wdt u_wdt (
    .clk_i(clk_i),
    .rst_i(any_rst),
    .tick_i(sub_tick),
    .clear_i(wdt_clear),
    .period_sel_i(wdog_ctl.period_sel),
    .timeout_o(wdt_to)
  );

  logic port_wake;
  logic [IRQ_W-1:0] irq_wake;

  pdw_wake #(
    .PORT_W(PORT_W),
    .IRQ_W(IRQ_W)
  ) u_wake (
    .clk_i(clk_i),
    .rst_i(any_rst),
    .tick_i(sub_tick),
    .arm_i(halt_take),
    .active_i(in_pd),
    .port_i(porta_s2),
    .port_mask_i(wake_mask),
    .irq_req_i(irq_req_i),
    .port_wake_o(port_wake),
    .irq_wake_o(irq_wake)
  );

  logic irq_serve;
  logic ev_wake;
  assign irq_serve = |(irq_wake & irq_en_i) && !stack_full_i;
  // any of the three wake sources
  assign ev_wake = port_wake || (|irq_wake) || wdt_to;

  // mode selection
  always_comb
  begin
    next_state = state;
    case (state)
      PDW_RUN:
      begin
        if (halt_take)
        begin
          if (!clkmode[`PDW_CLKMODE_IDLE_BIT])
            next_state = PDW_SLEEP;
          else if (sysctl[`PDW_SYSCTL_KEEP_BIT])
            next_state = PDW_IDLE_ON;
          else
            next_state = PDW_IDLE_OFF;
        end
      end
      PDW_SLEEP, PDW_IDLE_OFF, PDW_IDLE_ON:
      begin
        if (ev_wake)
          next_state = PDW_RUN;
      end
      default: next_state = PDW_RUN;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (any_rst)
      state <= PDW_RUN;
    else
      state <= next_state;
  end

  // clock gating and program freeze follow the state
  always_ff @(posedge clk_i)
  begin
    if (any_rst)
    begin
      pwr_o <= '{sys_clk_en: 1'b1, time_base_en: 1'b1, cpu_hold: 1'b0};
      mode_o <= PDW_RUN;
    end
    else
    begin
      pwr_o.sys_clk_en <= (next_state == PDW_RUN) ||
                          (next_state == PDW_IDLE_ON);
      pwr_o.time_base_en <= (next_state != PDW_SLEEP);
      pwr_o.cpu_hold <= (next_state != PDW_RUN);
      mode_o <= next_state;
    end
  end

  // reset and wake pulses
  always_ff @(posedge clk_i)
  begin
    if (any_rst)
    begin
      device_reset_o <= 1'b0;
      pc_sp_reset_o <= 1'b0;
      wake_o <= 1'b0;
      irq_service_o <= 1'b0;
    end
    else
    begin
      device_reset_o <= (wdt_to && !in_pd) || key_fire;
      // power-down timeout resets only pc and sp
      pc_sp_reset_o <= wdt_to && in_pd;
      // resume after halt unless timeout or service
      wake_o <= in_pd && !wdt_to && !irq_serve && (port_wake || (|irq_wake));
      // serve at once when enabled with stack room
      // otherwise resume and leave the request pending
      irq_service_o <= in_pd && !wdt_to && irq_serve;
    end
  end

  // status flags: of the resets only power-on clears them, other resets keep them; watchdog clear drops pd, halt drops tof
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pd_flag <= 1'b0;
    else if (halt_take)
      pd_flag <= 1'b1;
    else if (clear_watchdog_instr_i)
      pd_flag <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      tof <= 1'b0;
    else if (wdt_to)
      tof <= 1'b1;
    else if (halt_take)
      tof <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      powerdown_flag_o <= 1'b0;
      timeout_flag_o <= 1'b0;
    end
    else
    begin
      powerdown_flag_o <= pd_flag;
      timeout_flag_o <= tof;
    end
  end

  // wishbone slave, one wait state; write lands on the ack edge
  logic wb_req;
  logic wb_wr;
  assign wb_req = wb_cyc_i && wb_stb_i;
  assign wb_wr = wb_req && wb_ack_o && wb_we_i && wb_sel_i[0];

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    hit = (adr[7:2] == off[7:2]);
  endfunction

  logic [7:0] rd_byte;
  always_comb
  begin
    rd_byte = 8'h00;
    if (hit(wb_adr_i, `PDW_ADR_WDOG_CTL))
      rd_byte = wdog_ctl;
    else if (hit(wb_adr_i, `PDW_ADR_SYSCTL))
      rd_byte = {sysctl[7:1] & 7'h5b, key_rst_flag};
    else if (hit(wb_adr_i, `PDW_ADR_CLKMODE))
      rd_byte = clkmode;
    else if (hit(wb_adr_i, `PDW_ADR_WAKEMASK))
      rd_byte = 8'(wake_mask);
    else if (hit(wb_adr_i, `PDW_ADR_STATUS))
    begin
      rd_byte[`PDW_STATUS_TMO_BIT] = tof;
      rd_byte[`PDW_STATUS_PD_BIT] = pd_flag;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else
    begin
      wb_ack_o <= wb_req && !wb_ack_o;
      if (wb_req && !wb_ack_o)
        wb_dat_o <= {24'h0, rd_byte};
    end
  end

  // reload on reset, kept on power-down timeout
  always_ff @(posedge clk_i)
  begin
    if (any_rst)
      wdog_ctl <= `PDW_WDOG_CTL_RESET;
    else if (wb_wr && hit(wb_adr_i, `PDW_ADR_WDOG_CTL))
      wdog_ctl <= wb_dat_i[7:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (any_rst)
      sysctl <= 8'h00;
    else if (wb_wr && hit(wb_adr_i, `PDW_ADR_SYSCTL))
      sysctl <= wb_dat_i[7:0] & `PDW_SYSCTL_RW_MASK;
  end

  // set by key reset, set wins over clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      key_rst_flag <= 1'b0;
    else if (key_fire)
      key_rst_flag <= 1'b1;
    else if (wb_wr && hit(wb_adr_i, `PDW_ADR_SYSCTL) &&
             !wb_dat_i[`PDW_SYSCTL_KEYRST_BIT])
      key_rst_flag <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (any_rst)
      clkmode <= `PDW_CLKMODE_RESET;
    else if (wb_wr && hit(wb_adr_i, `PDW_ADR_CLKMODE))
      clkmode <= wb_dat_i[7:0] & `PDW_CLKMODE_RW_MASK;
  end

  // nothing here is touched by power-down entry
  always_ff @(posedge clk_i)
  begin
    if (any_rst)
      wake_mask <= '0;
    else if (wb_wr && hit(wb_adr_i, `PDW_ADR_WAKEMASK))
      wake_mask <= wb_dat_i[PORT_W-1:0];
  end

  // halt entry clears the counter through wdt_clear

endmodule // pdw_top

// file: pdw_props.sv
// checker of power-down, wake-up and watchdog behaviour at the top ports
`timescale 1ns/1ps

module pdw_props
  import pdw_pkg::*;
#(
  parameter int IRQ_W = 4
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic halt_i,
  input wire logic clear_watchdog_instr_i,
  input wire logic [IRQ_W-1:0] irq_en_i,
  input wire logic stack_full_i,
  input wire pdw_pwr_t pwr_o,
  input wire pdw_state_t mode_o,
  input wire logic pc_sp_reset_o,
  input wire logic wake_o,
  input wire logic irq_service_o,
  input wire logic powerdown_flag_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sleep_clocks_a: assert property (
    mode_o == PDW_SLEEP |-> !pwr_o.sys_clk_en && !pwr_o.time_base_en
      && pwr_o.cpu_hold) else $error("sleep clocks wrong");
  idle_off_clocks_a: assert property (
    mode_o == PDW_IDLE_OFF |-> !pwr_o.sys_clk_en && pwr_o.time_base_en
      && pwr_o.cpu_hold) else $error("idle off clocks wrong");
  idle_on_clocks_a: assert property (
    mode_o == PDW_IDLE_ON |-> pwr_o.sys_clk_en && pwr_o.cpu_hold)
    else $error("idle on clocks wrong");
  halt_sets_pdf_a: assert property (
    halt_i && mode_o == PDW_RUN && !clear_watchdog_instr_i |=> ##1 powerdown_flag_o)
    else $error("halt did not set powerdown flag");
  halt_leaves_run_a: assert property (
    halt_i && mode_o == PDW_RUN |=> mode_o != PDW_RUN)
    else $error("halt did not enter power-down");
  clear_drops_pdf_a: assert property (
    clear_watchdog_instr_i && !halt_i |=> ##1 !powerdown_flag_o)
    else $error("watchdog clear kept powerdown flag");
  wake_resumes_a: assert property (
    wake_o |-> mode_o == PDW_RUN && $past(mode_o) != PDW_RUN)
    else $error("wake without resume");
  pd_timeout_flag_a: assert property (
    pc_sp_reset_o |-> ##[1:2] powerdown_flag_o && $past(mode_o) == PDW_RUN)
    else $error("power-down timeout flags wrong");
  service_allowed_a: assert property (
    irq_service_o |-> $past(irq_en_i) != '0 && !$past(stack_full_i))
    else $error("interrupt serviced while not allowed");
  serve_not_resume_a: assert property (
    irq_service_o |-> !wake_o) else $error("wake and service together");

  cover property (mode_o == PDW_SLEEP);
  cover property (irq_service_o);
  cover property (pc_sp_reset_o);
endmodule // pdw_props

bind pdw_top pdw_props #(.IRQ_W(IRQ_W)) pdw_props_i (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .halt_i(halt_i),
  .clear_watchdog_instr_i(clear_watchdog_instr_i),
  .irq_en_i(irq_en_i),
  .stack_full_i(stack_full_i),
  .pwr_o(pwr_o),
  .mode_o(mode_o),
  .pc_sp_reset_o(pc_sp_reset_o),
  .wake_o(wake_o),
  .irq_service_o(irq_service_o),
  .powerdown_flag_o(powerdown_flag_o)
);

// file: pdw_core_model.sv
// core model issuing halt and watchdog clear instruction pulses
`timescale 1ns/1ps

module pdw_core_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic halt_cmd_i,
  input wire logic clr_cmd_i,
  input wire logic hold_i,
  output logic halt_o,
  output logic clear_watchdog_instr_o
);
  logic halt_q;
  logic clr_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      halt_q <= 1'b0;
      clr_q <= 1'b0;
      halt_o <= 1'b0;
      clear_watchdog_instr_o <= 1'b0;
    end
    else
    begin
      halt_q <= halt_cmd_i;
      clr_q <= clr_cmd_i;
      halt_o <= halt_cmd_i && !halt_q && !hold_i;
      clear_watchdog_instr_o <= clr_cmd_i && !clr_q && !hold_i;
    end
  end
endmodule // pdw_core_model

// file: tb_top.sv
// testbench of the power-down, wake-up and watchdog block
`timescale 1ns/1ps
`include "pdw_cfg.svh"

module tb_top
  import pdw_pkg::*;
;
  logic clk_i = 0;
  logic rst_i = 1;
  logic cyc = 0;
  logic stb = 0;
  logic we = 0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] dat_o;
  logic ack;
  logic halt;
  logic clr;
  logic sub = 0;
  logic halt_cmd = 0;
  logic clr_cmd = 0;
  logic [7:0] porta = 8'hff;
  logic [3:0] irq_req = 4'h0;
  logic [3:0] irq_en = 4'h0;
  logic stk = 0;
  pdw_pwr_t pwr;
  pdw_state_t mode;
  logic dev_rst, pcsp, wake, svc, pdn, tmo;
  logic [3:0] seen = 4'h0;
  logic clr_seen = 0;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  pdw_state_t exp_m [3] = '{PDW_SLEEP, PDW_IDLE_OFF, PDW_IDLE_ON};

  pdw_top pdw_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .halt_i(halt),
    .clear_watchdog_instr_i(clr), .sub_clk_i(sub), .porta_i(porta), .irq_req_i(irq_req),
    .irq_en_i(irq_en), .stack_full_i(stk), .pwr_o(pwr), .mode_o(mode),
    .device_reset_o(dev_rst), .pc_sp_reset_o(pcsp), .wake_o(wake),
    .irq_service_o(svc), .powerdown_flag_o(pdn), .timeout_flag_o(tmo));
  pdw_core_model pdw_core_model_i (.clk_i(clk_i), .rst_i(rst_i),
    .halt_cmd_i(halt_cmd), .clr_cmd_i(clr_cmd), .hold_i(pwr.cpu_hold),
    .halt_o(halt), .clear_watchdog_instr_o(clr));

  initial
  begin
    forever #5 clk_i = ~clk_i;
  end

  // pulses are short, so they are kept until the next wait starts
  always @(posedge clk_i)
    seen <= clr_seen ? 4'h0 : seen | {dev_rst, pcsp, svc, wake};

  task automatic complete_run();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      mismatches++;
      complete_run();
    end
  end

  task automatic chk(input string n, input logic [31:0] e,
    input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
    output logic [31:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    dat <= {24'h0, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd(input string n, input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    wb(1'b0, a, 8'h00, q);
    chk(n, {24'h0, e}, q);
  endtask

  task automatic core(input logic h);
    halt_cmd <= h;
    clr_cmd <= !h;
    @(posedge clk_i);
    halt_cmd <= 1'b0;
    clr_cmd <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask

  // sub clock runs at one eighth of the system clock
  task automatic ticks(input int n);
    clr_seen <= 1'b1;
    @(posedge clk_i);
    clr_seen <= 1'b0;
    // the clear lands on that edge; read seen only after it
    @(posedge clk_i);
    for (int i = 0; i < n && seen == 4'h0; i++)
    begin
      sub <= 1'b1;
      repeat (4) @(posedge clk_i);
      sub <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
  endtask

  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd("wdog_ctl", `PDW_ADR_WDOG_CTL, 8'h53);
    rd("sysctl", `PDW_ADR_SYSCTL, 8'h00);
    rd("clkmode", `PDW_ADR_CLKMODE, 8'h03);
    rd("status", `PDW_ADR_STATUS, 8'h00);
    rd("unmapped", 8'h14, 8'h00);
    wr(`PDW_ADR_SYSCTL, 8'hff);
    rd("sysctl", `PDW_ADR_SYSCTL, 8'hb6);
    wr(`PDW_ADR_WDOG_CTL, 8'ha8);
    rd("wdog_ctl", `PDW_ADR_WDOG_CTL, 8'ha8);
    wr(`PDW_ADR_WAKEMASK, 8'h01);
    for (int m = 0; m < 3; m++)
    begin
      wr(`PDW_ADR_CLKMODE, m > 0 ? 8'h03 : 8'h01);
      wr(`PDW_ADR_SYSCTL, m == 2 ? 8'h80 : 8'h00);
      core(1'b1);
      chk("mode", exp_m[m], mode);
      rd("status", `PDW_ADR_STATUS, 8'h10);
      porta <= 8'hfe;
      ticks(8);
      chk("events", 4'h1, seen);
      chk("mode", PDW_RUN, mode);
      porta <= 8'hff;
      ticks(2);
    end
    wr(`PDW_ADR_WAKEMASK, 8'h00);
    irq_req <= 4'h2;
    core(1'b1);
    porta <= 8'hfe;
    ticks(4);
    chk("events", 4'h0, seen);
    irq_en <= 4'h1;
    irq_req <= 4'h3;
    ticks(8);
    chk("events", 4'h2, seen);
    irq_req <= 4'h0;
    porta <= 8'hff;
    for (int j = 0; j < 2; j++)
    begin
      irq_en <= j == 1 ? 4'h1 : 4'h0;
      stk <= j == 1;
      core(1'b1);
      irq_req <= 4'h1;
      ticks(8);
      chk("events", 4'h1, seen);
      irq_req <= 4'h0;
    end
    stk <= 1'b0;
    irq_en <= 4'h0;
    core(1'b1);
    ticks(300);
    chk("events", 4'h4, seen);
    rd("status", `PDW_ADR_STATUS, 8'h30);
    chk("timeout_flag", 32'h1, tmo);
    chk("powerdown_flag", 32'h1, pdn);
    rd("wdog_ctl", `PDW_ADR_WDOG_CTL, 8'ha8);
    core(1'b0);
    rd("status", `PDW_ADR_STATUS, 8'h20);
    ticks(200);
    chk("events", 4'h0, seen);
    core(1'b0);
    ticks(300);
    chk("events", 4'h8, seen);
    rd("status", `PDW_ADR_STATUS, 8'h20);
    chk("timeout_flag", 32'h1, tmo);
    rd("wdog_ctl", `PDW_ADR_WDOG_CTL, 8'h53);
    core(1'b1);
    rd("status", `PDW_ADR_STATUS, 8'h10);
    chk("timeout_flag", 32'h0, tmo);
    wr(`PDW_ADR_WDOG_CTL, 8'h00);
    ticks(6);
    chk("events", 4'h8, seen);
    rd("sysctl", `PDW_ADR_SYSCTL, 8'h01);
    wr(`PDW_ADR_SYSCTL, 8'h00);
    rd("sysctl", `PDW_ADR_SYSCTL, 8'h00);
    complete_run();
  end
endmodule // tb_top
